// File: opstate_pkg.sv
// Package with states, timing figures and switch encodings of the operating-state controller.
// Assumes a single 125 MHz module clock.
package opstate_pkg;
    localparam int clk_mhz = 125;
    localparam int lamp_test_us = 100;
    localparam int lamp_test_cycles = lamp_test_us * clk_mhz;
    localparam int init_cycles = 16;
    localparam int fast_half_default = 8;
    localparam int slow_half_default = 64;
    localparam int div_w = 24;
    localparam logic [1:0] mom_mid = 2'h0;
    localparam logic [1:0] mom_up = 2'h1;
    localparam logic [1:0] mom_down = 2'h2;
    localparam logic [16:0] test_w_max = 17'h1ffff;
    typedef enum logic [2:0] {
        st_power_up, st_init, st_check, st_run, st_soft_stop, st_hard_stop
    } op_state_t;
endpackage

// File: flash_if.sv
// Interface carrying flash divider settings and flash phases.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface flash_if;
    logic [23:0] fast_half;
    logic [23:0] slow_half;
    logic fast_phase;
    logic slow_phase;
    modport gen (input fast_half, input slow_half, output fast_phase, output slow_phase);
    modport use_end (output fast_half, output slow_half, input fast_phase, input slow_phase);
endinterface
`default_nettype wire

// File: flash_gen.sv
// Programmable dividers making rapid and slow flash phases.
// Assumes half-periods are at least one cycle.
`timescale 1ns/1ps
`default_nettype none
module flash_gen (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Settings and phases.
    flash_if.gen fl
);
    import opstate_pkg::*;
    typedef struct packed {
        logic [div_w-1:0] fcnt;
        logic [div_w-1:0] scnt;
        logic fph;
        logic sph;
    } fg_t;
    fg_t q, next_q;
    function automatic logic [div_w:0] tick(input logic [div_w-1:0] c, input logic [div_w-1:0] half);
        tick = (c + 24'h1 >= half) ? {1'b1, 24'h0} : {1'b0, c + 24'h1};
    endfunction
    always_comb begin
        logic [div_w:0] f;
        logic [div_w:0] s;
        f = tick(q.fcnt, fl.fast_half);
        s = tick(q.scnt, fl.slow_half);
        next_q = q;
        next_q.fcnt = f[div_w-1:0];
        next_q.scnt = s[div_w-1:0];
        next_q.fph = q.fph ^ f[div_w];
        next_q.sph = q.sph ^ s[div_w];
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
    assign fl.fast_phase = q.fph;
    assign fl.slow_phase = q.sph;
endmodule
`default_nettype wire

// File: opstate_ctrl.sv
// Operating-state controller: run/stop and momentary switches, state sequencing, lamps.
// Assumes switch inputs already debounced and synchronous to sys_clk; rst is power-on.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Run switch and run state: execute program cyclically, green lamp on.
// - Run to stop switch move: soft stop, stop lamp steady, others off.
// - Switch down: reinitialize, erase RAM, then load card if present.
// - Switch up: clear flags, timers, counters, image; call restart block, start program.
// - Soft stop may run soft-stop block cyclically; digital outputs stay inhibited.
// - Hard stop runs nothing, ignores switches, left only by power cycle.
// - Run state: run lamp on, stop and fault lamps off.
// - After power-up all three lamps lit briefly.
// - Initial start and program check: all lamps off.
// - Overall reset requested: soft stop with stop lamp flashing rapidly.
// - Error-caused soft stop: stop lamp flashes slowly.
// - Hard stop: only system fault lamp lit.
module opstate_ctrl #(
    parameter int lamp_test_len = opstate_pkg::lamp_test_cycles
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Front-panel switches.
    input wire logic run_switch,
    input wire logic [1:0] mom_switch,
    // Events from the processor.
    input wire logic card_present,
    input wire logic erase_done,
    input wire logic copy_done,
    input wire logic check_done,
    input wire logic os_reset_request,
    input wire logic error_event,
    input wire logic fatal_event,
    // Flash settings.
    input wire logic [opstate_pkg::div_w-1:0] fast_half,
    input wire logic [opstate_pkg::div_w-1:0] slow_half,
    // Processor control.
    output logic run_program,
    output logic run_soft_stop_block,
    output logic outputs_inhibited,
    output logic erase_ram,
    output logic copy_card,
    output logic clear_retained,
    output logic call_restart_handler_block,
    output logic resume_program,
    output logic [2:0] state_code,
    // Lamps.
    output logic run_lamp,
    output logic stop_lamp,
    output logic system_fault_lamp
);
    import opstate_pkg::*;
    typedef struct packed {
        op_state_t st;
        logic [16:0] cnt;
        logic run_prev;
        logic ovr_req;
        logic err;
        logic erase;
        logic copy;
        logic clr;
        logic call;
        logic resume;
        logic rl;
        logic sl;
        logic fl;
        logic run_p;
        logic sb;
        logic inh;
    } ctl_t;
    ctl_t q, next_q;
    flash_if fli ();
    assign fli.fast_half = fast_half;
    assign fli.slow_half = slow_half;
    flash_gen u_flash (
        .sys_clk(sys_clk),
        .rst(rst),
        .fl(fli)
    );
    always_comb begin
        next_q = q;
        next_q.run_prev = run_switch;
        next_q.erase = 1'b0;
        next_q.copy = 1'b0;
        next_q.clr = 1'b0;
        next_q.call = 1'b0;
        next_q.resume = 1'b0;
        unique case (q.st)
            st_power_up: begin
                next_q.cnt = q.cnt + 17'h1;
                if (q.cnt >= 17'(lamp_test_len - 1)) begin
                    next_q.st = st_init;
                    next_q.cnt = '0;
                end
            end
            st_init: begin
                next_q.cnt = q.cnt + 17'h1;
                if (q.cnt >= 17'(init_cycles - 1)) begin
                    next_q.st = st_check;
                end
            end
            st_check: begin
                if (check_done && !fatal_event) begin
                    next_q.st = st_soft_stop;
                end
            end
            st_run: begin
                if (!fatal_event) begin
                    if (error_event) begin
                        next_q.err = 1'b1;
                        next_q.st = st_soft_stop;
                    end else if (os_reset_request) begin
                        next_q.ovr_req = 1'b1;
                        next_q.st = st_soft_stop;
                    end else if (q.run_prev && !run_switch) begin
                        next_q.st = st_soft_stop;
                    end
                end
            end
            st_soft_stop: begin
                if (os_reset_request || error_event) begin
                    next_q.ovr_req = q.ovr_req | os_reset_request;
                    next_q.err = q.err | error_event;
                end else if (fatal_event) begin
                    next_q.st = st_hard_stop;
                end else if (mom_switch == mom_down) begin
                    next_q.ovr_req = 1'b1;
                    next_q.erase = 1'b1;
                end else if (q.erase || q.copy) begin
                    // Copying starts only once the erase has finished, so the card never lands in stale RAM.
                    next_q.erase = q.erase & ~erase_done;
                    next_q.copy = (q.copy & ~copy_done) | (q.erase & erase_done & card_present);
                    if ((q.erase && erase_done && !card_present) || (q.copy && copy_done)) begin
                        next_q.ovr_req = 1'b0;
                    end
                end else if (run_switch && !q.ovr_req && mom_switch == mom_up) begin
                    next_q.clr = 1'b1;
                    next_q.call = 1'b1;
                    next_q.err = 1'b0;
                    next_q.st = st_run;
                end else if (run_switch && !q.ovr_req && !q.err && !q.run_prev) begin
                    next_q.resume = 1'b1;
                    next_q.st = st_run;
                end
            end
            st_hard_stop: begin
                next_q.st = st_hard_stop;
            end
        endcase
        // A fatal event wins over any move that the state itself chose, in every state but power-up.
        if (fatal_event && q.st != st_power_up) begin
            next_q.st = st_hard_stop;
        end
        next_q.run_p = next_q.st == st_run;
        next_q.sb = next_q.st == st_soft_stop;
        next_q.inh = next_q.st != st_run;
        next_q.rl = next_q.st == st_run || next_q.st == st_power_up;
        next_q.fl = next_q.st == st_hard_stop || next_q.st == st_power_up;
        if (next_q.st == st_soft_stop) begin
            if (next_q.ovr_req) begin
                next_q.sl = fli.fast_phase;
            end else if (next_q.err) begin
                next_q.sl = fli.slow_phase;
            end else begin
                next_q.sl = 1'b1;
            end
        end else begin
            next_q.sl = next_q.st == st_power_up;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '{st: st_power_up, rl: 1'b1, sl: 1'b1, fl: 1'b1, inh: 1'b1, default: '0};
        end else begin
            q <= next_q;
        end
    end
    assign run_program = q.run_p;
    assign run_soft_stop_block = q.sb;
    assign outputs_inhibited = q.inh;
    assign erase_ram = q.erase;
    assign copy_card = q.copy;
    assign clear_retained = q.clr;
    assign call_restart_handler_block = q.call;
    assign resume_program = q.resume;
    assign state_code = q.st;
    assign run_lamp = q.rl;
    assign stop_lamp = q.sl;
    assign system_fault_lamp = q.fl;

    hard_stop_sticks_a: assert property (@(posedge sys_clk) disable iff (rst)
        q.st == st_hard_stop |=> q.st == st_hard_stop) else $error("left hard stop");
    hard_lamps_a: assert property (@(posedge sys_clk) disable iff (rst)
        q.st == st_hard_stop |=> system_fault_lamp && !run_lamp && !stop_lamp) else $error("hard lamps");
    run_lamps_a: assert property (@(posedge sys_clk) disable iff (rst)
        q.st == st_run |-> run_lamp && !stop_lamp && !system_fault_lamp && run_program) else $error("run lamps");
    soft_inhibit_a: assert property (@(posedge sys_clk) disable iff (rst)
        q.st == st_soft_stop |-> outputs_inhibited && !run_program) else $error("outputs live");
    check_dark_a: assert property (@(posedge sys_clk) disable iff (rst)
        q.st inside {st_init, st_check} |-> !run_lamp && !stop_lamp && !system_fault_lamp) else $error("lit");
    stop_entry_a: assert property (@(posedge sys_clk) disable iff (rst)
        q.st == st_run && q.run_prev && !run_switch && !fatal_event && !error_event && !os_reset_request
        |=> q.st == st_soft_stop && stop_lamp) else $error("no stop");
    reset_call_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(call_restart_handler_block) |-> clear_retained && q.st == st_run) else $error("no restart call");
    overall_erase_a: assert property (@(posedge sys_clk) disable iff (rst)
        erase_ram |-> q.ovr_req && q.st == st_soft_stop) else $error("stray erase");
    power_lamps_a: assert property (@(posedge sys_clk) disable iff (rst)
        q.st == st_power_up |-> run_lamp && stop_lamp && system_fault_lamp) else $error("no lamp test");
    resume_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
        resume_program |-> !clear_retained && q.st == st_run) else $error("resume cleared");
    fast_flash_a: assert property (@(posedge sys_clk) disable iff (rst)
        q.st == st_soft_stop && q.ovr_req |-> stop_lamp == $past(fli.fast_phase)) else $error("no rapid flash");
    slow_flash_a: assert property (@(posedge sys_clk) disable iff (rst)
        q.st == st_soft_stop && !q.ovr_req && q.err |-> stop_lamp == $past(fli.slow_phase)) else $error("no slow flash");
    copy_after_erase_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(copy_card) |-> $past(erase_ram) && !erase_ram) else $error("copy before erase end");
    cov_resume: cover property (@(posedge sys_clk) disable iff (rst) resume_program);
    cov_run: cover property (@(posedge sys_clk) disable iff (rst) q.st == st_run);
    cov_ovr: cover property (@(posedge sys_clk) disable iff (rst) erase_ram);
    cov_err: cover property (@(posedge sys_clk) disable iff (rst) q.err && q.st == st_soft_stop);
    cov_hard: cover property (@(posedge sys_clk) disable iff (rst) q.st == st_hard_stop);
endmodule
`default_nettype wire

// File: front_panel.sv
// Operator model at the front panel: sets switch positions and watches the stop lamp.
// Assumes the lamps are registered on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module front_panel (
    // Clock.
    input wire logic sys_clk,
    // Operator intent.
    input wire logic want_run,
    input wire logic [1:0] want_mom,
    input wire logic clr,
    // Switches.
    output logic run_switch,
    output logic [1:0] mom_switch,
    // Lamp observation.
    input wire logic stop_lamp,
    output logic [15:0] toggles
);
    logic last_stop;
    assign run_switch = want_run;
    assign mom_switch = want_mom;
    // Counts stop lamp changes so that the two flash rates can be told apart.
    always @(posedge sys_clk) begin
        last_stop <= stop_lamp;
        if (clr) begin
            toggles <= 16'h0;
        end else if (stop_lamp !== last_stop) begin
            toggles <= toggles + 16'h1;
        end
    end
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the operating-state controller.
// Assumes a short lamp test of 8 cycles, a rapid half-period of 8 then 4 cycles and a slow one of 64.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import opstate_pkg::*;
    logic sys_clk = 0, rst = 1, want_run = 0, clr = 0, card_present = 0;
    logic erase_done = 0, copy_done = 0, check_done = 0, os_reset_request = 0;
    logic error_event = 0, fatal_event = 0, run_switch;
    logic [1:0] want_mom = mom_mid, mom_switch;
    logic run_program, run_soft_stop_block, outputs_inhibited, erase_ram, copy_card;
    logic clear_retained, call_restart_handler_block, resume_program;
    logic run_lamp, stop_lamp, system_fault_lamp;
    logic [2:0] state_code, seen;
    logic seen_clr = 1;
    logic [23:0] fast_half = 24'h8;
    logic [15:0] toggles;
    int miscompares = 0, check_count = 0, cycles = 0;

    always #4 sys_clk = ~sys_clk;

    front_panel panel_u (.sys_clk(sys_clk), .want_run(want_run), .want_mom(want_mom), .clr(clr),
        .run_switch(run_switch), .mom_switch(mom_switch), .stop_lamp(stop_lamp), .toggles(toggles));

    opstate_ctrl #(.lamp_test_len(8)) dut_u (.sys_clk(sys_clk), .rst(rst), .run_switch(run_switch),
        .mom_switch(mom_switch), .card_present(card_present), .erase_done(erase_done),
        .copy_done(copy_done), .check_done(check_done), .os_reset_request(os_reset_request),
        .error_event(error_event), .fatal_event(fatal_event), .fast_half(fast_half), .slow_half(24'h40),
        .run_program(run_program), .run_soft_stop_block(run_soft_stop_block),
        .outputs_inhibited(outputs_inhibited), .erase_ram(erase_ram), .copy_card(copy_card),
        .clear_retained(clear_retained), .call_restart_handler_block(call_restart_handler_block),
        .resume_program(resume_program), .state_code(state_code), .run_lamp(run_lamp),
        .stop_lamp(stop_lamp), .system_fault_lamp(system_fault_lamp));

    // Records the one-cycle pulses so they can be checked after the fact.
    always @(posedge sys_clk) begin
        if (seen_clr) begin
            seen <= 3'h0;
        end else begin
            seen <= seen | {clear_retained, call_restart_handler_block, resume_program};
        end
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic lamps(input logic [2:0] exp);
        check("lamps", 16'({run_lamp, stop_lamp, system_fault_lamp}), 16'(exp));
    endtask

    task automatic wait_state(input logic [2:0] s);
        int n;
        n = 0;
        while (state_code !== s && n < 200) begin
            step(1);
            n++;
        end
        check("state_code", 16'(state_code), 16'(s));
    endtask

    task automatic measure(input int lo, input int hi);
        clr = 1;
        step(1);
        clr = 0;
        step(128);
        check("flash toggles", 16'(toggles >= lo && toggles <= hi), 16'h1);
        check("run and fault lamps", 16'({run_lamp, system_fault_lamp}), 16'h0);
    endtask

    task automatic finish_test();
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        step(6);
        lamps(3'h7);
        check("inhibit", 16'(outputs_inhibited), 16'h1);
        rst = 0;
        wait_state(3'h1);
        lamps(3'h0);
        wait_state(3'h2);
        lamps(3'h0);
        check_done = 1;
        wait_state(3'h4);
        check_done = 0;
        lamps(3'h2);
        check("inhibit", 16'(outputs_inhibited), 16'h1);
        check("soft stop block", 16'(run_soft_stop_block), 16'h1);
        seen_clr = 1;
        want_run = 1;
        want_mom = mom_up;
        step(1);
        seen_clr = 0;
        want_mom = mom_mid;
        wait_state(3'h3);
        step(2);
        check("reset pulses", 16'(seen), 16'h6);
        lamps(3'h4);
        check("run_program", 16'(run_program), 16'h1);
        check("run outputs", 16'({outputs_inhibited, run_soft_stop_block}), 16'h0);
        want_run = 0;
        wait_state(3'h4);
        step(8);
        lamps(3'h2);
        seen_clr = 1;
        want_run = 1;
        wait_state(3'h3);
        seen_clr = 0;
        step(2);
        check("restart pulses", 16'(seen), 16'h1);
        want_run = 0;
        wait_state(3'h4);
        card_present = 1;
        want_mom = mom_down;
        step(2);
        want_mom = mom_mid;
        step(2);
        check("erase_ram", 16'(erase_ram), 16'h1);
        check("copy during erase", 16'(copy_card), 16'h0);
        measure(15, 17);
        fast_half = 24'h4;
        measure(31, 33);
        erase_done = 1;
        step(1);
        erase_done = 0;
        step(2);
        check("copy_card", 16'(copy_card), 16'h1);
        copy_done = 1;
        step(1);
        copy_done = 0;
        step(2);
        check("memory ops", 16'({erase_ram, copy_card}), 16'h0);
        error_event = 1;
        step(1);
        error_event = 0;
        step(2);
        measure(1, 3);
        os_reset_request = 1;
        step(1);
        os_reset_request = 0;
        step(2);
        measure(31, 33);
        fatal_event = 1;
        step(1);
        fatal_event = 0;
        wait_state(3'h5);
        lamps(3'h1);
        want_run = 1;
        want_mom = mom_up;
        step(20);
        check("hard stop", 16'({state_code, run_program}), 16'ha);
        finish_test();
    end
endmodule
`default_nettype wire
